// file: src/ctio_pkg.sv
// package of constants for the camera trigger input and output logic
package ctio_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS    = 10_000;                   // 100 MHz clock period
    localparam int STRETCH_NS       = 50;                       // input stretch time
    localparam int STRETCH_CYC      = (STRETCH_NS * 1000) / CLK_PERIOD_PS;   // rounded down, 5
    localparam int MIN_IN_NS        = 8;                        // narrowest input pulse the source gives
    localparam int PULSE_NS         = 500;                      // output pulse width
    localparam int PULSE_CYC        = (PULSE_NS * 1000) / CLK_PERIOD_PS;     // 50
    localparam int OFFSET_MAX_US    = 1849;                     // largest pre-integration offset
    localparam int OFFSET_MAX_CYC   = (OFFSET_MAX_US * 1_000_000) / CLK_PERIOD_PS; // 184900
    localparam int OFFSET_W         = 18;                       // width of offset in cycles
    localparam int PULSE_W          = 8;                        // width of pulse counter

    // ****************************************************************
    // operating modes
    // ****************************************************************
    typedef enum logic [2:0] {
        CTIO_MODE_INT_SW   = 3'h0,                              // internal sync, software start
        CTIO_MODE_INT_HWST = 3'h1,                              // internal sync, hardware start
        CTIO_MODE_INT_HWEN = 3'h2,                              // internal sync, hardware enable
        CTIO_MODE_SINGLE   = 3'h3,                              // single shot on external trigger
        CTIO_MODE_EXT_SYNC = 3'h4                               // external sync, software start
    } ctio_mode_t;

endpackage : ctio_pkg

// file: src/ctio_pulse_gen.sv
// delayed fixed-width pulse generator for the trigger output
`timescale 1ns/1ps
module ctio_pulse_gen
    import ctio_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC                      // output pulse width in cycles
) (
    input  wire logic                clk_i,                     // system clock
    input  wire logic                rst_i,                     // asynchronous reset, active high
    input  wire logic                start_i,                   // launch request, one cycle
    input  wire logic [ctio_pkg::OFFSET_W-1:0] delay_i,         // cycles before the pulse rises
    output logic                     pulse_o                    // registered output pulse
);
    import ctio_pkg::*;

    // ****************************************************************
    // counters
    // ****************************************************************
    localparam int PG_TAIL = PULSE_CYCLES - 7;                  // cycles from eighth high to first low
    typedef enum logic [1:0] {
        PG_IDLE  = 2'b00,                                       // waiting for launch
        PG_WAIT  = 2'b01,                                       // counting the offset
        PG_PULSE = 2'b11                                        // output high
    } ctio_pg_state_t;

    ctio_pg_state_t      state_reg, state_next;                 // sequencer state
    logic [OFFSET_W-1:0] dly_reg, dly_next;                     // offset down-counter
    logic [PULSE_W-1:0]  wid_reg, wid_next;                     // pulse width counter
    logic                pulse_reg, pulse_next;                 // output flop

    // next state, counters restart on each launch taken in idle
    always_comb begin
        state_next = state_reg;
        dly_next   = dly_reg;
        wid_next   = wid_reg;
        pulse_next = 1'b0;
        unique case (state_reg)
            PG_IDLE: begin
                if (start_i) begin                              // restart for this frame [RQ12]
                    wid_next = '0;
                    if (delay_i == '0) begin
                        state_next = PG_PULSE;
                        pulse_next = 1'b1;
                    end else begin
                        dly_next   = delay_i - OFFSET_W'(1);
                        state_next = PG_WAIT;
                    end
                end
            end
            PG_WAIT: begin
                if (dly_reg == '0) begin                        // offset elapsed [RQ8]
                    state_next = PG_PULSE;
                    pulse_next = 1'b1;
                end else begin
                    dly_next = dly_reg - OFFSET_W'(1);
                end
            end
            PG_PULSE: begin
                if (wid_reg == PULSE_W'(PULSE_CYCLES - 1)) begin  // fixed width ends [RQ4] [RQ5]
                    state_next = PG_IDLE;
                end else begin
                    wid_next   = wid_reg + PULSE_W'(1);
                    pulse_next = 1'b1;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= PG_IDLE;
            dly_reg   <= '0;
            wid_reg   <= '0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dly_reg   <= dly_next;
            wid_reg   <= wid_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse_o = pulse_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
        $rose(pulse_reg) |-> pulse_reg [*8] ##PG_TAIL !pulse_reg)
        else $error("output pulse width wrong");

    chk_zero_delay: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
        (state_reg == PG_IDLE && start_i && delay_i == '0) |=> pulse_reg)
        else $error("pulse late with zero offset");

endmodule : ctio_pulse_gen

// file: src/ctio_top.sv
// trigger input conditioning and trigger output timing of the camera controller
//
// Overview of operation
// RQ1 - stretch each accepted input pulse to 50 ns
// RQ2 - source drives input pulses at least 8 ns
// RQ3 - input role follows selected operating mode
// RQ4 - each output event is one 500 ns pulse
// RQ5 - fixed width gives 0.5 us edge resolution
// RQ6 - output marks integration start outside external sync
// RQ7 - external sync: output marks integration end
// RQ8 - programmable offset 0 to 1849 us ahead
// RQ9 - software enable gates all output pulses
// RQ10 - five operating modes supported
// RQ11 - trigger recognised on rising input edge
// RQ12 - counters on internal clock restart per frame
`timescale 1ns/1ps
module ctio_top
    import ctio_pkg::*;
#(
    parameter int OFFSET_MAX = OFFSET_MAX_CYC                   // largest offset in cycles
) (
    input  wire logic                         CLK_I,            // 100 MHz clock
    input  wire logic                         SYS_RST_I,        // asynchronous reset, active high
    input  wire logic                         TRIG_IN_I,        // external trigger pin
    input  wire ctio_pkg::ctio_mode_t         MODE_I,           // selected operating mode
    input  wire logic                         SW_START_I,       // software capture start, one cycle
    input  wire logic                         TRIG_OUT_EN_I,    // software output enable
    input  wire logic                         SHUTTER_I,        // sensor in shutter mode
    input  wire logic [ctio_pkg::OFFSET_W-1:0] OFFSET_CYC_I,    // pre-integration offset, cycles
    input  wire logic                         INTEG_START_I,    // integration starts (schedule), pulse
    input  wire logic                         INTEG_END_I,      // integration ends, pulse
    output logic                              TRIG_OUT_O,       // external trigger output
    output logic                              CAPTURE_START_O,  // capture start, pulse
    output logic                              CAPTURE_EN_O,     // capture enable level
    output logic                              SHOT_O,           // single-shot trigger, pulse
    output logic                              SYNC_O,           // sync trigger, pulse
    output logic                              TRIG_SEEN_O       // stretched trigger level
);
    import ctio_pkg::*;

    // ****************************************************************
    // input synchroniser and edge detect
    // ****************************************************************
    logic       sync1_reg, sync2_reg, sync3_reg;                // two-flop synchroniser, then history
    wire  logic trig_rise;                                      // rising edge seen

    // pin passes two flops before use
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= TRIG_IN_I;                             // relies on >= 8 ns pulses [RQ2]
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign trig_rise = sync2_reg & ~sync3_reg;                  // rising edge only [RQ11]

    // ****************************************************************
    // pulse stretcher
    // ****************************************************************
    logic [3:0] str_cnt_reg, str_cnt_next;                      // stretch down-counter
    logic       str_reg;                                        // stretched level
    wire  logic accept;                                         // new pulse accepted

    assign accept       = trig_rise & ~str_reg;
    // load the full count so the level stands for all STRETCH_CYC cycles
    assign str_cnt_next = accept ? 4'(STRETCH_CYC)
                        : (str_cnt_reg != 4'h0) ? str_cnt_reg - 4'h1 : 4'h0;

    // hold the trigger for the stretch time
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            str_cnt_reg <= 4'h0;
            str_reg     <= 1'b0;
        end else begin
            str_cnt_reg <= str_cnt_next;                        // [RQ1]
            str_reg     <= accept | (str_cnt_next != 4'h0);     // [RQ1]
        end
    end

    // ****************************************************************
    // role of the trigger per mode
    // ****************************************************************
    wire logic is_hwst   = (MODE_I == CTIO_MODE_INT_HWST);
    wire logic is_hwen   = (MODE_I == CTIO_MODE_INT_HWEN);
    wire logic is_single = (MODE_I == CTIO_MODE_SINGLE);
    wire logic is_ext    = (MODE_I == CTIO_MODE_EXT_SYNC);
    wire logic sw_mode   = (MODE_I == CTIO_MODE_INT_SW) | is_ext;  // software capture start [RQ10]
    wire logic start_nxt = (is_hwst & accept) | (sw_mode & SW_START_I);

    logic cap_start_reg, cap_en_reg, shot_reg, sync_reg;        // role outputs

    // route the accepted trigger to its role, the synchronised pin level to the enable
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cap_start_reg <= 1'b0;
            cap_en_reg    <= 1'b0;
            shot_reg      <= 1'b0;
            sync_reg      <= 1'b0;
        end else begin
            cap_start_reg <= start_nxt;                         // [RQ3] [RQ10]
            cap_en_reg    <= is_hwen & sync2_reg;               // enable while input high [RQ3]
            shot_reg      <= is_single & accept;                // [RQ3] [RQ10]
            sync_reg      <= is_ext & accept;                   // [RQ3] [RQ10]
        end
    end

    // ****************************************************************
    // trigger output
    // ****************************************************************
    wire  logic                launch;                          // frame event for output
    wire  logic [OFFSET_W-1:0] delay;                           // clamped offset
    logic                      pulse_w;                         // generator pulse
    logic                      out_reg;                         // gated output flop

    // start in most modes, end in external sync [RQ6] [RQ7]
    assign launch = TRIG_OUT_EN_I & (is_ext ? INTEG_END_I : INTEG_START_I);  // [RQ9]
    // offset only applies in shutter mode, and not at integration end [RQ8]
    assign delay  = (!SHUTTER_I || is_ext) ? '0
                  : (OFFSET_CYC_I > OFFSET_W'(OFFSET_MAX)) ? OFFSET_W'(OFFSET_MAX) : OFFSET_CYC_I;

    ctio_pulse_gen #(
        .PULSE_CYCLES (PULSE_CYC)
    ) u_pulse (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .start_i (launch),
        .delay_i (delay),
        .pulse_o (pulse_w)
    );

    // output flop, gated by the enable
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= pulse_w & TRIG_OUT_EN_I;                 // [RQ9]
        end
    end

    assign TRIG_OUT_O      = out_reg;
    assign CAPTURE_START_O = cap_start_reg;
    assign CAPTURE_EN_O    = cap_en_reg;
    assign SHOT_O          = shot_reg;
    assign SYNC_O          = sync_reg;
    assign TRIG_SEEN_O     = str_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_stretch_len: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ1]
        $rose(str_reg) |-> str_reg [*5] ##1 !str_reg)
        else $error("stretch length wrong");

    chk_rise_only: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ11]
        $rose(str_reg) |-> $past(sync2_reg) && !$past(sync3_reg))
        else $error("trigger taken without rising edge");

    chk_out_disabled: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ9]
        !$past(TRIG_OUT_EN_I) |-> !TRIG_OUT_O)
        else $error("output pulse while disabled");

    chk_start_mark: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ6]
        (INTEG_START_I && TRIG_OUT_EN_I && !is_ext && !SHUTTER_I && !pulse_w) ##1 TRIG_OUT_EN_I
        |-> ##1 TRIG_OUT_O)
        else $error("no output at integration start");

    chk_end_mark: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ7]
        (INTEG_END_I && TRIG_OUT_EN_I && is_ext && !pulse_w) ##1 TRIG_OUT_EN_I |-> ##1 TRIG_OUT_O)
        else $error("no output at integration end");

    chk_shot_role: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ3]
        SHOT_O |-> $past(is_single) && !SYNC_O && !CAPTURE_START_O)
        else $error("single shot in wrong mode");

    chk_hw_start: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ10]
        (accept && is_hwst) |=> CAPTURE_START_O)
        else $error("hardware start missed");

    chk_out_width: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // [RQ4]
        ($rose(TRIG_OUT_O) && TRIG_OUT_EN_I) ##1 TRIG_OUT_EN_I [*8] |-> TRIG_OUT_O)
        else $error("output pulse cut short");

endmodule : ctio_top

// file: verification/ctio_far_end.sv
// behavioural trigger source on the far side of the trigger input pin
`timescale 1ns/1ps
module ctio_far_end #(
    parameter int WIDTH_NS = 8                  // narrowest pulse the source gives
) (
    input  wire logic fire_i,                   // bench request for one pulse
    output logic      trig_o                    // drive of the trigger pin
);
    // pin rests low between pulses; one clean high pulse per request,
    // never narrower than the minimum, from a single process
    initial begin
        trig_o = 1'b0;
        forever begin
            @(posedge fire_i);
            trig_o = 1'b1;
            #WIDTH_NS;
            trig_o = 1'b0;
        end
    end
endmodule : ctio_far_end

// file: verification/testbench.sv
// self-checking testbench for the camera trigger block
`timescale 1ns/1ps
module testbench;
    import ctio_pkg::*;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic                clk, rst, fire, pin, sw_go, out_en, shut, i_start, i_end;
    ctio_mode_t          mode;                  // selected operating mode
    logic [OFFSET_W-1:0] ofs;                   // offset in cycles
    logic                tout, cst, cen, shot, sync, seen;
    int                  miscompares = 0;
    int                  compares = 0;

    ctio_far_end u_ctio_far_end (.fire_i(fire), .trig_o(pin));
    ctio_top u_ctio_top (.CLK_I(clk), .SYS_RST_I(rst), .TRIG_IN_I(pin), .MODE_I(mode),
        .SW_START_I(sw_go), .TRIG_OUT_EN_I(out_en), .SHUTTER_I(shut), .OFFSET_CYC_I(ofs),
        .INTEG_START_I(i_start), .INTEG_END_I(i_end), .TRIG_OUT_O(tout), .CAPTURE_START_O(cst),
        .CAPTURE_EN_O(cen), .SHOT_O(shot), .SYNC_O(sync), .TRIG_SEEN_O(seen));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check

    // one-cycle schedule event, then delay to output rise and its width
    task automatic launch(input logic use_end, output int dly, output int wid);
        dly = 0;
        wid = 0;
        @(negedge clk);
        if (use_end) i_end = 1'b1;
        else i_start = 1'b1;
        @(negedge clk);
        i_end = 1'b0;
        i_start = 1'b0;
        for (int i = 1; i < 400; i++) begin
            @(negedge clk);
            if (tout === 1'b1) begin
                if (dly == 0) dly = i + 1;      // counted from the edge that raised the event
                wid++;
            end
        end
    endtask : launch

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // input pin roles per mode; second edge lands while stretched
    task automatic test_roles(input logic twice);
        logic [3:0] role_exp [5];
        int n_seen, n_st, n_en, n_sh, n_sy;
        role_exp = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
        for (int m = 0; m < 5; m++) begin
            n_seen = 0; n_st = 0; n_en = 0; n_sh = 0; n_sy = 0;
            mode = ctio_mode_t'(m);
            @(negedge clk);
            for (int i = 0; i < 24; i++) begin
                fire = (i == 0 || (twice && i == 3));
                @(negedge clk);
                n_seen += (seen === 1'b1);
                n_st += (cst === 1'b1);
                n_en += (cen === 1'b1);
                n_sh += (shot === 1'b1);
                n_sy += (sync === 1'b1);
            end
            check("stretched level width", STRETCH_CYC, n_seen);
            check("capture start count", role_exp[m][3], n_st);
            check("capture enable count", role_exp[m][2] * (twice ? 2 : 1), n_en);
            check("single shot count", role_exp[m][1], n_sh);
            check("sync trigger count", role_exp[m][0], n_sy);
        end
        $display("test input roles done, second edge %0d", twice);
    endtask : test_roles

    // software capture start in modes 0 and 4
    task automatic test_sw_start;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            mode = (k == 0) ? CTIO_MODE_INT_SW : CTIO_MODE_EXT_SYNC;
            @(negedge clk);
            sw_go = 1'b1;
            // the start pulse stands in the first cycle after the request
            repeat (6) begin
                @(negedge clk);
                sw_go = 1'b0;
                n += (cst === 1'b1);
            end
            check("software capture start", 1, n);
        end
        $display("test software start done");
    endtask : test_sw_start

    // output pulse source, width, offset and enable
    task automatic test_output;
        int d, w;
        mode = CTIO_MODE_INT_SW;
        launch(1'b0, d, w);
        check("start delay", 2, d);
        check("pulse width", PULSE_CYC, w);
        launch(1'b1, d, w);
        check("end ignored outside ext sync", 0, w);
        mode = CTIO_MODE_EXT_SYNC;
        launch(1'b0, d, w);
        check("start ignored in ext sync", 0, w);
        shut = 1'b1;
        ofs = 18'h0_0014;
        launch(1'b1, d, w);
        check("end delay in ext sync", 2, d);
        check("pulse width ext sync", PULSE_CYC, w);
        mode = CTIO_MODE_INT_HWST;
        launch(1'b0, d, w);
        check("offset delay", 22, d);
        check("pulse width with offset", PULSE_CYC, w);
        ofs = 18'h0_0000;
        launch(1'b0, d, w);
        check("zero offset delay", 2, d);
        out_en = 1'b0;
        launch(1'b0, d, w);
        check("disabled output", 0, w);
        out_en = 1'b1;
        shut = 1'b0;
        $display("test trigger output done");
    endtask : test_output

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test

    // ****************************************************************
    // clock, main sequence and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1; fire = 1'b0; sw_go = 1'b0; out_en = 1'b1; shut = 1'b0;
        i_start = 1'b0; i_end = 1'b0; mode = CTIO_MODE_INT_SW; ofs = 18'h0_0000;
        repeat (4) @(negedge clk);
        check("outputs in reset", 0, {tout, cst, cen, shot, sync, seen});
        rst = 1'b0;
        @(negedge clk);
        check("outputs after reset", 0, {tout, cst, cen, shot, sync, seen});
        test_roles(1'b0);
        test_roles(1'b1);
        test_sw_start;
        test_output;
        finish_test;
    end

    // cut a hang short well past the expected run time
    initial begin
        #200us;
        miscompares++;
        finish_test;
    end
endmodule : testbench
